// >>> pkg/core_regs_pkg.sv
// shared constants for the core register set
// assumes one 20 MHz clock and a synchronous active-low reset
package core_regs_pkg;
    localparam int          DATA_W        = 32;
    localparam int          NUM_GP        = 13;
    localparam int          IDX_W         = 4;
    localparam int          EXC_W         = 9;
    localparam int          PRIO_W        = 9;
    localparam int          CLK_MHZ       = 20;
    // operand index map
    localparam logic [3:0]  IDX_LOW_LAST  = 4'h7;
    localparam logic [3:0]  IDX_GP_LAST   = 4'hC;
    localparam logic [3:0]  IDX_STACK     = 4'hD;
    localparam logic [3:0]  IDX_LINK      = 4'hE;
    localparam logic [3:0]  IDX_IPTR      = 4'hF;
    // special register port offsets
    localparam logic [3:0]  SR_PSW        = 4'h0;
    localparam logic [3:0]  SR_FLAGS      = 4'h1;
    localparam logic [3:0]  SR_EXCNUM     = 4'h2;
    localparam logic [3:0]  SR_EXEC       = 4'h3;
    localparam logic [3:0]  SR_EMASK      = 4'h4;
    localparam logic [3:0]  SR_FMASK      = 4'h5;
    localparam logic [3:0]  SR_PRIO       = 4'h6;
    localparam logic [3:0]  SR_MODE       = 4'h7;
    localparam logic [3:0]  SR_MSP        = 4'h8;
    localparam logic [3:0]  SR_PSP        = 4'h9;
    // status word field layout
    localparam int          FLAGS_LSB     = 27;
    localparam int          FLAGS_MSB     = 31;
    localparam int          EXC_LSB       = 0;
    localparam int          EXC_MSB       = 8;
    localparam int          ICI_LSB       = 10;
    localparam int          ICI_MSB       = 15;
    localparam int          ITHI_LSB      = 25;
    localparam int          ITHI_MSB      = 26;
    localparam int          TBIT          = 24;
    localparam logic [31:0] FLAGS_MASK    = 32'hF800_0000;
    localparam logic [31:0] EXEC_MASK     = 32'h0600_FC00;
    localparam logic [31:0] SP_ALIGN_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFE;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [31:0] EXEC_RESET    = 32'h0100_0000;
    localparam logic [8:0]  PRIO_RESET    = 9'h000;
    localparam logic [1:0]  MODE_RESET    = 2'h0;
    localparam int          MODE_USER     = 0;
    localparam int          MODE_ALTSP    = 1;
    // instruction encoding widths
    typedef enum logic [1:0] {
        ENC_NONE = 2'b00,
        ENC_16   = 2'b01,
        ENC_32   = 2'b11
    } enc_t;
endpackage

// >>> logic/operand_port.sv
// one operand read port of the core register set
// assumes the register values arrive already aligned
`timescale 1ns/1ns
module operand_port
    import core_regs_pkg::*;
(
    input  wire logic [3:0]        idx,
    input  wire logic              enc32,
    input  wire logic              high_ok16,
    input  wire logic [DATA_W-1:0] gp_val,
    input  wire logic [DATA_W-1:0] sp_val,
    input  wire logic [DATA_W-1:0] lr_val,
    input  wire logic [DATA_W-1:0] pc_val,
    output logic      [DATA_W-1:0] data,
    output logic                   legal
);
    always_comb begin
        data  = gp_val;
        legal = 1'b1;
        if (idx <= IDX_LOW_LAST) begin
            legal = 1'b1;
        end else if (idx <= IDX_GP_LAST) begin
            legal = enc32 | high_ok16;
        end else if (idx == IDX_STACK) begin
            data = sp_val;
        end else if (idx == IDX_LINK) begin
            data = lr_val;
        end else begin
            data = pc_val;
        end
    end
endmodule // operand_port

// >>> logic/mask_gate.sv
// decides whether a pending exception may be taken under the masks
// assumes lower priority value means more urgent
`timescale 1ns/1ns
module mask_gate
    import core_regs_pkg::*;
(
    input  wire logic              is_nmi,
    input  wire logic              is_hardfault,
    input  wire logic [PRIO_W-1:0] prio,
    input  wire logic              emask,
    input  wire logic              fmask,
    input  wire logic [PRIO_W-1:0] threshold,
    output logic                   allow
);
    logic thr_block;
    always_comb begin
        thr_block = (threshold != PRIO_RESET) && (prio >= threshold);
        if (is_nmi) begin
            allow = 1'b1;
        end else if (fmask) begin
            allow = 1'b0;
        end else if (is_hardfault) begin
            allow = 1'b1;
        end else if (emask) begin
            allow = 1'b0;
        end else begin
            allow = ~thr_block;
        end
    end
endmodule // mask_gate

// >>> logic/core_register_file.sv
// architectural register set: general bank, banked stack pointer,
// return link, instruction pointer, status word, masks and mode control
// assumes the core pipeline drives operand indices and write strobes
`timescale 1ns/1ns

// Functional notes
// - all core registers are 32 bits wide
// - low eight registers usable by every encoding
// - registers 8-12 only some 16-bit encodings
// - stack pointer low two bits read zero
// - return link captures address on call
// - instruction pointer bit zero reads zero
// - result flags in status bits 27-31
// - exception number in status bits 0-8
// - execution state bits 10-15 and 25-26
// - bit 24 stays one; clearing faults
// - status parts accessed combined or separately
// - exception mask allows only nmi, hardfault
// - fault mask allows only nmi
// - threshold blocks equal or lower urgency
// - threshold zero disables masking
// - mode bit zero selects user level
// - mode bit one selects alternate stack; code also uses it for user thread with bit one clear
// - mode bit one zero in handler
// - handler mode while servicing, always privileged
// - user level special access faults, except flags access and status word reads
module core_register_file
    import core_regs_pkg::*;
#(
    parameter int GP_COUNT = NUM_GP
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // operand read ports
    input  wire logic [3:0]        rd_a_idx,
    input  wire logic [3:0]        rd_b_idx,
    input  wire logic [1:0]        rd_enc,
    input  wire logic              rd_high_ok16,
    output logic      [DATA_W-1:0] rd_a_data,
    output logic      [DATA_W-1:0] rd_b_data,
    output logic                   rd_illegal,
    // result write port
    input  wire logic              wr_en,
    input  wire logic [3:0]        wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    // pipeline side
    input  wire logic              pc_load,
    input  wire logic [DATA_W-1:0] pc_next,
    input  wire logic              call_en,
    input  wire logic [DATA_W-1:0] call_ret,
    input  wire logic              flags_en,
    input  wire logic [4:0]        flags_in,
    input  wire logic              exc_enter,
    input  wire logic              exc_return,
    input  wire logic [EXC_W-1:0]  exc_num,
    // pending exception to gate
    input  wire logic              pend_valid,
    input  wire logic              pend_nmi,
    input  wire logic              pend_hardfault,
    input  wire logic [PRIO_W-1:0] pend_prio,
    // special register plain port
    input  wire logic [3:0]        sr_addr,
    input  wire logic [DATA_W-1:0] sr_wdata,
    input  wire logic              sr_wr,
    input  wire logic              sr_rd,
    output logic      [DATA_W-1:0] sr_rdata,
    // state outputs
    output logic      [DATA_W-1:0] stack_ptr,
    output logic      [DATA_W-1:0] instruction_pointer,
    output logic                   handler_mode,
    output logic                   user_level,
    output logic                   take_exception,
    output logic                   fault
);
    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [DATA_W-1:0] gp_r     [GP_COUNT];
    logic [DATA_W-1:0] gp_nxt   [GP_COUNT];
    logic [DATA_W-1:0] msp_r,   msp_nxt;
    logic [DATA_W-1:0] psp_r,   psp_nxt;
    logic [DATA_W-1:0] lr_r,    lr_nxt;
    logic [DATA_W-1:0] pc_r,    pc_nxt;
    logic [4:0]        flags_r, flags_nxt;
    logic [EXC_W-1:0]  excn_r,  excn_nxt;
    logic [DATA_W-1:0] exec_r,  exec_nxt;
    logic              emask_r, emask_nxt;
    logic              fmask_r, fmask_nxt;
    logic [PRIO_W-1:0] prio_r,  prio_nxt;
    logic [1:0]        mode_r,  mode_nxt;
    logic [DATA_W-1:0] srd_r,   srd_nxt;
    logic              illg_r,  illg_nxt;
    logic              take_r,  take_nxt;
    logic              fault_r, fault_nxt;
    logic [DATA_W-1:0] rda_r,   rdb_r;
    logic [DATA_W-1:0] spo_r,   spo_nxt;
    logic              hdl_r,   hdl_nxt, usr_r, usr_nxt;

    ////////////////////////////////////////////////////////////////////////
    // views
    logic              in_handler;
    logic              is_user;
    logic              use_psp;
    logic [DATA_W-1:0] sp_view;
    logic [DATA_W-1:0] pc_view;
    logic [DATA_W-1:0] psw_view;
    logic [3:0]        gpi_a, gpi_b;
    logic [DATA_W-1:0] opa, opb;
    logic              lega, legb;
    logic              allow;

    assign in_handler = (excn_r != '0);
    assign is_user    = ~in_handler & mode_r[MODE_USER];
    // user thread always on process stack
    assign use_psp    = ~in_handler & (mode_r[MODE_ALTSP] | mode_r[MODE_USER]);
    assign sp_view    = (use_psp ? psp_r : msp_r) & SP_ALIGN_MASK;
    assign pc_view    = pc_r & PC_ALIGN_MASK;
    assign psw_view   = {flags_r, ZERO_WORD[FLAGS_LSB-1:EXC_MSB+1], excn_r} | (exec_r & EXEC_MASK)
                        | EXEC_RESET;
    assign gpi_a      = (rd_a_idx <= IDX_GP_LAST) ? rd_a_idx : 4'h0;
    assign gpi_b      = (rd_b_idx <= IDX_GP_LAST) ? rd_b_idx : 4'h0;

    operand_port u_port_a (
        .idx       (rd_a_idx),
        .enc32     (rd_enc == ENC_32),
        .high_ok16 (rd_high_ok16),
        .gp_val    (gp_r[gpi_a]),
        .sp_val    (sp_view),
        .lr_val    (lr_r),
        .pc_val    (pc_view),
        .data      (opa),
        .legal     (lega)
    );

    operand_port u_port_b (
        .idx       (rd_b_idx),
        .enc32     (rd_enc == ENC_32),
        .high_ok16 (rd_high_ok16),
        .gp_val    (gp_r[gpi_b]),
        .sp_val    (sp_view),
        .lr_val    (lr_r),
        .pc_val    (pc_view),
        .data      (opb),
        .legal     (legb)
    );

    mask_gate u_gate (
        .is_nmi       (pend_nmi),
        .is_hardfault (pend_hardfault),
        .prio         (pend_prio),
        .emask        (emask_r),
        .fmask        (fmask_r),
        .threshold    (prio_r),
        .allow        (allow)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        for (int i = 0; i < GP_COUNT; i++) begin
            gp_nxt[i] = gp_r[i];
        end
        msp_nxt   = msp_r;
        psp_nxt   = psp_r;
        lr_nxt    = lr_r;
        pc_nxt    = pc_r;
        flags_nxt = flags_r;
        excn_nxt  = excn_r;
        exec_nxt  = exec_r;
        emask_nxt = emask_r;
        fmask_nxt = fmask_r;
        prio_nxt  = prio_r;
        mode_nxt  = mode_r;
        srd_nxt   = ZERO_WORD;
        fault_nxt = 1'b0;
        illg_nxt  = (rd_enc != ENC_NONE) & ~(lega & legb);
        take_nxt  = pend_valid & allow;

        // general write port
        if (wr_en) begin
            if (wr_idx <= IDX_GP_LAST) begin
                gp_nxt[wr_idx] = wr_data;
            end else if (wr_idx == IDX_STACK) begin
                if (use_psp) begin
                    psp_nxt = wr_data & SP_ALIGN_MASK;
                end else begin
                    msp_nxt = wr_data & SP_ALIGN_MASK;
                end
            end else if (wr_idx == IDX_LINK) begin
                lr_nxt = wr_data;
            end else begin
                pc_nxt = wr_data & PC_ALIGN_MASK;
            end
        end
        if (pc_load) begin
            pc_nxt = pc_next & PC_ALIGN_MASK;
        end
        if (call_en) begin
            lr_nxt = call_ret;
        end
        if (flags_en) begin
            flags_nxt = flags_in;
        end

        // special register writes, blocked at user level except flags
        if (sr_wr) begin
            if (sr_addr == SR_FLAGS) begin
                flags_nxt = sr_wdata[FLAGS_MSB:FLAGS_LSB];
            end else if (is_user) begin
                fault_nxt = 1'b1;
            end else if (sr_addr == SR_PSW) begin
                flags_nxt = sr_wdata[FLAGS_MSB:FLAGS_LSB];
                exec_nxt  = (sr_wdata & EXEC_MASK) | EXEC_RESET;
                fault_nxt = ~sr_wdata[TBIT];
            end else if (sr_addr == SR_EXEC) begin
                exec_nxt  = (sr_wdata & EXEC_MASK) | EXEC_RESET;
                fault_nxt = ~sr_wdata[TBIT];
            end else if (sr_addr == SR_EMASK) begin
                emask_nxt = sr_wdata[0];
            end else if (sr_addr == SR_FMASK) begin
                fmask_nxt = sr_wdata[0];
            end else if (sr_addr == SR_PRIO) begin
                prio_nxt = sr_wdata[PRIO_W-1:0];
            end else if (sr_addr == SR_MODE) begin
                mode_nxt[MODE_USER]  = sr_wdata[MODE_USER];
                mode_nxt[MODE_ALTSP] = sr_wdata[MODE_ALTSP] & ~in_handler;
            end else if (sr_addr == SR_MSP) begin
                msp_nxt = sr_wdata & SP_ALIGN_MASK;
            end else if (sr_addr == SR_PSP) begin
                psp_nxt = sr_wdata & SP_ALIGN_MASK;
            end
        end

        // special register reads, one cycle later
        if (sr_rd) begin
            if (sr_addr == SR_PSW) begin
                srd_nxt = psw_view;
            end else if (sr_addr == SR_FLAGS) begin
                srd_nxt = psw_view & FLAGS_MASK;
            end else if (is_user) begin
                fault_nxt = 1'b1;
            end else if (sr_addr == SR_EXCNUM) begin
                srd_nxt = {23'h00_0000, excn_r};
            end else if (sr_addr == SR_EXEC) begin
                srd_nxt = (exec_r & EXEC_MASK) | EXEC_RESET;
            end else if (sr_addr == SR_EMASK) begin
                srd_nxt = {31'h0000_0000, emask_r};
            end else if (sr_addr == SR_FMASK) begin
                srd_nxt = {31'h0000_0000, fmask_r};
            end else if (sr_addr == SR_PRIO) begin
                srd_nxt = {23'h00_0000, prio_r};
            end else if (sr_addr == SR_MODE) begin
                srd_nxt = {30'h0000_0000, mode_r};
            end else if (sr_addr == SR_MSP) begin
                srd_nxt = msp_r & SP_ALIGN_MASK;
            end else if (sr_addr == SR_PSP) begin
                srd_nxt = psp_r & SP_ALIGN_MASK;
            end
        end

        // exception entry/return moves between thread and handler
        if (exc_enter) begin
            excn_nxt = exc_num;
        end else if (exc_return) begin
            excn_nxt = '0;
        end
        if (exc_enter && exc_num != '0) begin
            mode_nxt[MODE_ALTSP] = 1'b0;
        end
        hdl_nxt = (excn_nxt != '0);
        usr_nxt = ~hdl_nxt & mode_nxt[MODE_USER];
        spo_nxt = (usr_nxt | ~hdl_nxt & mode_nxt[MODE_ALTSP]) ? psp_nxt : msp_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < GP_COUNT; i++) begin
                gp_r[i] <= ZERO_WORD;
            end
            msp_r   <= ZERO_WORD;
            psp_r   <= ZERO_WORD;
            lr_r    <= ZERO_WORD;
            pc_r    <= ZERO_WORD;
            flags_r <= 5'h00;
            excn_r  <= 9'h000;
            exec_r  <= EXEC_RESET;
            emask_r <= 1'b0;
            fmask_r <= 1'b0;
            prio_r  <= PRIO_RESET;
            mode_r  <= MODE_RESET;
            srd_r   <= ZERO_WORD;
            illg_r  <= 1'b0;
            take_r  <= 1'b0;
            fault_r <= 1'b0;
            rda_r   <= ZERO_WORD;
            rdb_r   <= ZERO_WORD;
            hdl_r   <= 1'b0;
            usr_r   <= 1'b0;
            spo_r   <= ZERO_WORD;
        end else begin
            for (int i = 0; i < GP_COUNT; i++) begin
                gp_r[i] <= gp_nxt[i];
            end
            msp_r   <= msp_nxt;
            psp_r   <= psp_nxt;
            lr_r    <= lr_nxt;
            pc_r    <= pc_nxt;
            flags_r <= flags_nxt;
            excn_r  <= excn_nxt;
            exec_r  <= exec_nxt;
            emask_r <= emask_nxt;
            fmask_r <= fmask_nxt;
            prio_r  <= prio_nxt;
            mode_r  <= mode_nxt;
            srd_r   <= srd_nxt;
            illg_r  <= illg_nxt;
            take_r  <= take_nxt;
            fault_r <= fault_nxt;
            rda_r   <= opa;
            rdb_r   <= opb;
            hdl_r   <= hdl_nxt;
            usr_r   <= usr_nxt;
            spo_r   <= spo_nxt;
        end
    end

    assign rd_a_data           = rda_r;
    assign rd_b_data           = rdb_r;
    assign rd_illegal          = illg_r;
    assign sr_rdata            = srd_r;
    assign stack_ptr           = spo_r;
    assign instruction_pointer = pc_r;
    assign handler_mode        = hdl_r;
    assign user_level          = usr_r;
    assign take_exception      = take_r;
    assign fault               = fault_r;
endmodule // core_register_file

// >>> sim/core_register_file_asserts.sv
// concurrent checks on the ports of the core register set
// assumes binding onto core_register_file, one clock domain
`timescale 1ns/1ns
module core_register_file_asserts
    import core_regs_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic [3:0]        rd_a_idx,
    input wire logic [3:0]        rd_b_idx,
    input wire logic [1:0]        rd_enc,
    input wire logic              rd_high_ok16,
    input wire logic              rd_illegal,
    input wire logic              pc_load,
    input wire logic [DATA_W-1:0] pc_next,
    input wire logic              exc_enter,
    input wire logic              exc_return,
    input wire logic [EXC_W-1:0]  exc_num,
    input wire logic              pend_valid,
    input wire logic              pend_nmi,
    input wire logic [3:0]        sr_addr,
    input wire logic              sr_wr,
    input wire logic              sr_rd,
    input wire logic [DATA_W-1:0] sr_rdata,
    input wire logic [DATA_W-1:0] stack_ptr,
    input wire logic [DATA_W-1:0] instruction_pointer,
    input wire logic              handler_mode,
    input wire logic              user_level,
    input wire logic              take_exception,
    input wire logic              fault
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////////
    stack_align_a: assert property (stack_ptr[1:0] == 2'h0)
        else $error("stack pointer low bits not zero");
    iptr_load_a: assert property (pc_load |=> instruction_pointer == ($past(pc_next) & PC_ALIGN_MASK))
        else $error("instruction pointer load wrong");
    rdata_idle_a: assert property (!sr_rd |=> sr_rdata == 32'h0000_0000)
        else $error("special read data not idle");
    nmi_taken_a: assert property (pend_valid && pend_nmi |=> take_exception)
        else $error("nmi not taken");
    no_pend_a: assert property (!pend_valid |=> !take_exception)
        else $error("exception taken without request");
    handler_priv_a: assert property (handler_mode |-> !user_level)
        else $error("handler at user level");
    exc_entry_a: assert property (exc_enter && !exc_return && exc_num != 9'h000 |=> handler_mode)
        else $error("no handler mode after entry");
    exc_exit_a: assert property (exc_return && !exc_enter |=> !handler_mode)
        else $error("handler mode after return");
    user_fault_a: assert property (user_level && (sr_wr || sr_rd) && sr_addr inside {[SR_EXCNUM:SR_PSP]} |=> fault)
        else $error("no fault on user special access");
    user_read_a: assert property (user_level && sr_rd && sr_addr inside {[SR_EXCNUM:SR_PSP]} |=> sr_rdata == '0)
        else $error("user special read not zero");
    high_ill_a: assert property (rd_enc == ENC_16 && !rd_high_ok16 && rd_a_idx > IDX_LOW_LAST
                                 && rd_a_idx <= IDX_GP_LAST |=> rd_illegal)
        else $error("high register select not refused");
    low_legal_a: assert property (rd_a_idx <= IDX_LOW_LAST && rd_b_idx <= IDX_LOW_LAST |=> !rd_illegal)
        else $error("low register select refused");
    wide_legal_a: assert property (rd_enc == ENC_32 |=> !rd_illegal)
        else $error("wide encoding select refused");

    take_c: cover property (take_exception);
    fault_c: cover property (fault);
    handler_c: cover property (handler_mode);
endmodule // core_register_file_asserts

// >>> sim/cpu_core_register_file_tb.sv
// self-checking bench for the core register set
// assumes core_register_file with its checker bound below
`timescale 1ns/1ns
module cpu_core_register_file_tb;
    import core_regs_pkg::*;
    logic        clk_sys, resetn, rd_high_ok16, wr_en, pc_load, call_en, flags_en, flt;
    logic        exc_enter, exc_return, pend_valid, pend_nmi, pend_hardfault, sr_wr, sr_rd;
    logic [3:0]  rd_a_idx, rd_b_idx, wr_idx, sr_addr;
    logic [1:0]  rd_enc;
    logic [4:0]  flags_in;
    logic [8:0]  exc_num, pend_prio;
    logic [31:0] wr_data, pc_next, call_ret, sr_wdata;
    logic [31:0] rd_a_data, rd_b_data, sr_rdata, stack_ptr, instruction_pointer;
    logic        rd_illegal, handler_mode, user_level, take_exception, fault;
    int          miscompares, num_checks;

    core_register_file dut_u (.clk_sys, .resetn, .rd_a_idx, .rd_b_idx, .rd_enc, .rd_high_ok16, .rd_a_data,
        .rd_b_data, .rd_illegal, .wr_en, .wr_idx, .wr_data, .pc_load, .pc_next, .call_en, .call_ret, .flags_en,
        .flags_in, .exc_enter, .exc_return, .exc_num, .pend_valid, .pend_nmi, .pend_hardfault, .pend_prio,
        .sr_addr, .sr_wdata, .sr_wr, .sr_rd, .sr_rdata, .stack_ptr, .instruction_pointer, .handler_mode,
        .user_level, .take_exception, .fault);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // drop strobes at the taking edge, then read the answers
    task automatic fin();
        @(posedge clk_sys);
        {sr_wr, sr_rd, wr_en, pc_load, call_en, flags_en, exc_enter, exc_return, pend_valid} <= '0;
        #1;
        flt = fault;
    endtask

    task automatic sw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sr_addr <= a;
        sr_wdata <= d;
        sr_wr <= 1'b1;
        fin();
    endtask

    task automatic sr(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        sr_addr <= a;
        sr_rd <= 1'b1;
        fin();
        chk("sr_rdata", sr_rdata, e);
    endtask

    task automatic gw(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_data <= d;
        fin();
    endtask

    task automatic op(input logic [3:0] i, input logic [1:0] e, input logic h, input logic [31:0] d,
                      input logic ill);
        @(posedge clk_sys);
        rd_a_idx <= i;
        rd_b_idx <= i;
        rd_enc <= e;
        rd_high_ok16 <= h;
        fin();
        chk("rd_illegal", 32'(rd_illegal), 32'(ill));
        if (!ill) begin
            chk("rd_a_data", rd_a_data, d);
            chk("rd_b_data", rd_b_data, d);
        end
    endtask

    task automatic pend(input logic n, input logic h, input logic [8:0] p, input logic t);
        @(posedge clk_sys);
        pend_valid <= 1'b1;
        pend_nmi <= n;
        pend_hardfault <= h;
        pend_prio <= p;
        fin();
        chk("take_exception", 32'(take_exception), 32'(t));
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        results();
    end

    initial begin
        {rd_high_ok16, wr_en, pc_load, call_en, flags_en, exc_enter, exc_return, pend_valid} = '0;
        {pend_nmi, pend_hardfault, sr_wr, sr_rd, rd_a_idx, rd_b_idx, wr_idx, sr_addr, rd_enc} = '0;
        {flags_in, exc_num, pend_prio, wr_data, pc_next, call_ret, sr_wdata} = '0;
        {resetn, miscompares, num_checks, flt} = '0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 4; i < 10; i++) sr(4'(i), 32'h0000_0000);
        sr(SR_EXEC, 32'h0100_0000);
        sr(SR_PSW, 32'h0100_0000);
        sw(SR_PRIO, 32'h0000_0005);
        sr(SR_PRIO, 32'h0000_0005);
        pend(1'b0, 1'b0, 9'h005, 1'b0);
        pend(1'b0, 1'b0, 9'h006, 1'b0);
        pend(1'b0, 1'b0, 9'h004, 1'b1);
        sw(SR_PRIO, 32'h0000_01FF);
        sr(SR_PRIO, 32'h0000_01FF);
        pend(1'b0, 1'b0, 9'h1FE, 1'b1);
        sw(SR_PRIO, 32'h0000_0000);
        pend(1'b0, 1'b0, 9'h1FF, 1'b1);
        sw(SR_EMASK, 32'h0000_0001);
        pend(1'b0, 1'b0, 9'h000, 1'b0);
        sr(SR_EMASK, 32'h0000_0001);
        pend(1'b0, 1'b1, 9'h1FF, 1'b1);
        pend(1'b1, 1'b0, 9'h1FF, 1'b1);
        sw(SR_FMASK, 32'h0000_0001);
        pend(1'b0, 1'b1, 9'h000, 1'b0);
        pend(1'b1, 1'b0, 9'h000, 1'b1);
        sw(SR_EMASK, 32'h0000_0000);
        sw(SR_FMASK, 32'h0000_0000);
        pend(1'b0, 1'b1, 9'h000, 1'b1);
        for (int i = 0; i < 13; i++) gw(4'(i), 32'hF0E1_D2C3 + 32'(i));
        for (int i = 0; i < 13; i++) begin
            op(4'(i), ENC_32, 1'b0, 32'hF0E1_D2C3 + 32'(i), 1'b0);
            op(4'(i), ENC_16, 1'b0, 32'hF0E1_D2C3 + 32'(i), 1'(i > 7));
            op(4'(i), ENC_16, 1'b1, 32'hF0E1_D2C3 + 32'(i), 1'b0);
        end
        @(posedge clk_sys);
        call_en <= 1'b1;
        call_ret <= 32'h8000_1235;
        wr_en <= 1'b1;
        wr_idx <= IDX_LINK;
        fin();
        op(IDX_LINK, ENC_32, 1'b0, 32'h8000_1235, 1'b0);
        @(posedge clk_sys);
        pc_load <= 1'b1;
        pc_next <= 32'h0000_2003;
        wr_en <= 1'b1;
        wr_idx <= IDX_IPTR;
        fin();
        chk("instruction_pointer", instruction_pointer, 32'h0000_2002);
        sw(SR_MSP, 32'h2000_0107);
        sr(SR_MSP, 32'h2000_0104);
        chk("stack_ptr", stack_ptr, 32'h2000_0104);
        sw(SR_PSP, 32'h3000_00FF);
        sw(SR_MODE, 32'h0000_0002);
        chk("stack_ptr", stack_ptr, 32'h3000_00FC);
        gw(IDX_STACK, 32'h3000_0013);
        op(IDX_STACK, ENC_32, 1'b0, 32'h3000_0010, 1'b0);
        @(posedge clk_sys);
        exc_enter <= 1'b1;
        exc_num <= 9'h00B;
        fin();
        chk("handler_mode", 32'(handler_mode), 32'h0000_0001);
        chk("stack_ptr", stack_ptr, 32'h2000_0104);
        sr(SR_MODE, 32'h0000_0000);
        sw(SR_MODE, 32'h0000_0002);
        sr(SR_MODE, 32'h0000_0000);
        sr(SR_EXCNUM, 32'h0000_000B);
        @(posedge clk_sys);
        flags_en <= 1'b1;
        flags_in <= 5'h15;
        fin();
        sr(SR_PSW, 32'hA900_000B);
        sr(SR_FLAGS, 32'hA800_0000);
        @(posedge clk_sys);
        exc_return <= 1'b1;
        fin();
        chk("handler_mode", 32'(handler_mode), 32'h0000_0000);
        sw(SR_EXEC, 32'h0000_0000);
        chk("fault", 32'(flt), 32'h0000_0001);
        sr(SR_EXEC, 32'h0100_0000);
        sw(SR_EXEC, 32'h0700_FC00);
        chk("fault", 32'(flt), 32'h0000_0000);
        sr(SR_EXEC, 32'h0700_FC00);
        sw(SR_MODE, 32'h0000_0001);
        chk("user_level", 32'(user_level), 32'h0000_0001);
        chk("stack_ptr", stack_ptr, 32'h3000_0010);
        sw(SR_PRIO, 32'h0000_0003);
        chk("fault", 32'(flt), 32'h0000_0001);
        sr(SR_PRIO, 32'h0000_0000);
        sw(SR_FLAGS, 32'h5000_0000);
        chk("fault", 32'(flt), 32'h0000_0000);
        sr(SR_FLAGS, 32'h5000_0000);
        @(posedge clk_sys);
        exc_enter <= 1'b1;
        exc_num <= 9'h003;
        fin();
        chk("user_level", 32'(user_level), 32'h0000_0000);
        results();
    end
endmodule // cpu_core_register_file_tb

bind core_register_file core_register_file_asserts chk_u (.clk_sys, .resetn, .rd_a_idx, .rd_b_idx, .rd_enc,
    .rd_high_ok16, .rd_illegal, .pc_load, .pc_next, .exc_enter, .exc_return, .exc_num, .pend_valid, .pend_nmi,
    .sr_addr, .sr_wr, .sr_rd, .sr_rdata, .stack_ptr, .instruction_pointer, .handler_mode, .user_level,
    .take_exception, .fault);
